// ### common/hub_cfg_pkg.sv
// package: offsets, field positions and reset values of the device configuration register
package hub_cfg_pkg;
    localparam logic [3:0] DEVICE_CONFIGURATION_OFFSET = 4'h5;
    localparam int SERIAL_WE_BIT = 6;
    localparam int LPM_DISABLE_BIT = 5;
    localparam int RESERVED_ONE_BIT = 4;
    localparam int GANGED_BIT = 3;
    localparam int PM_OFF_N_BIT = 2;
    localparam logic SERIAL_WE_RESET = 1'h0;
    localparam logic LPM_DISABLE_RESET = 1'h0;
    localparam logic RESERVED_ONE_VALUE = 1'h1;
    localparam int NUM_PORTS = 2;
endpackage

// ### src/port_power_route.sv
// port power routing: individual or ganged switching of the downstream port power controls
`timescale 1ns/10ps
`default_nettype none
module port_power_route #(
    parameter int PORTS = 2
) (
    input wire logic ganged_i,                  // with pm_off_n_i low, first control carries the OR of all requests, the others stay off
    input wire logic pm_off_n_i,                // high disables switching
    input wire logic [PORTS-1:0] port_req_i,    // per-port power requests
    output logic [PORTS-1:0] port_power_o       // resulting power enables
);
    logic any_req;
    assign any_req = |port_req_i;
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            always_comb begin
                if (pm_off_n_i) begin
                    // switching disabled: ports are left powered
                    port_power_o[g] = 1'b1;   // RL9
                end else if (ganged_i) begin
                    port_power_o[g] = (g == 0) ? any_req : 1'b0;   // RL7
                end else begin
                    port_power_o[g] = port_req_i[g];   // RL7
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### src/hub_device_config_bits.sv
// device configuration register, bits 6 down to 2, with straps and low-power gating
// Contract
// RL1: serial write enable resets to 0; gates serial string writes.
// RL2: low-power disable 1 blocks initiating and accepting U1/U2 on all ports.
// RL3: forced link-PM accept re-enables U1/U2 until power-on reset or upstream disconnect.
// RL4: I2C mode loads bits 5,3,2 from EEPROM; SMBus host may overwrite them.
// RL5: bit 4 is reserved and always reads 1.
// RL6: ganging bit captured from its strap pin at reset release.
// RL7: ganging 0 per-port switching; 1 all ports on first control pin.
// RL8: power-management bit captured from its strap pin at reset release.
// RL9: power_mgmt_off_n 0 enables switching and over-current reporting; 1 disables both.
// RL10: register sits at offset 5h.
`timescale 1ns/10ps
`default_nettype none
module hub_device_config_bits #(
    parameter int PORTS = hub_cfg_pkg::NUM_PORTS
) (
    input wire logic mclk_i,                     // 100 MHz clock
    input wire logic rstn_i,                     // async reset, active low
    input wire logic ce_i,                       // clock enable
    input wire logic ganging_strap_pin_i,        // ganging strap
    input wire logic power_mgmt_strap_pin_i,     // power management strap
    input wire logic i2c_mode_i,                 // eeprom load mode
    input wire logic smbus_mode_i,               // smbus slave mode
    input wire logic cfg_wr_i,                   // register write strobe
    input wire logic [3:0] cfg_addr_i,           // register offset
    input wire logic [7:0] cfg_wdata_i,          // write data
    input wire logic force_lpm_accept_i,         // forced link-PM accept sent or received
    input wire logic upstream_disconnect_i,      // upstream port disconnected
    input wire logic u1u2_req_i,                 // incoming or local U1/U2 request
    input wire logic overcurrent_i,              // raw over-current indication
    input wire logic [PORTS-1:0] port_req_i,     // per-port power requests
    input wire logic serial_wr_i,                // serial string write attempt
    output logic [7:0] cfg_rdata_o,              // register read data
    output logic serial_string_write_enable_o,   // serial strings writable
    output logic u1u2_allowed_o,                 // U1/U2 may be initiated/accepted
    output logic serial_wr_ok_o,                 // serial string write performed
    output logic overcurrent_report_o,           // over-current reported
    output logic [PORTS-1:0] port_power_control_pins_o  // port power controls
);
    // ------------------------------------------------------------
    // address and mode decoding
    // ------------------------------------------------------------
    logic hit;
    logic mode_on;
    logic cfg_write_ok;
    logic strap_done_q, strap_done_d;

    function automatic logic addr_hit(input logic [3:0] a);
        addr_hit = (a == hub_cfg_pkg::DEVICE_CONFIGURATION_OFFSET);   // RL10
    endfunction

    // either configuration source may load or overwrite the register
    function automatic logic mode_active(input logic i2c, input logic smb);
        mode_active = i2c | smb;   // RL4
    endfunction

    // readable byte; bits 7, 1 and 0 belong to other logic and read 0 here
    function automatic logic [7:0] read_byte(
        input logic serial_we,
        input logic lpm_dis,
        input logic ganged,
        input logic pm_off_n
    );
        read_byte = 8'h00;
        read_byte[hub_cfg_pkg::SERIAL_WE_BIT] = serial_we;
        read_byte[hub_cfg_pkg::LPM_DISABLE_BIT] = lpm_dis;
        read_byte[hub_cfg_pkg::RESERVED_ONE_BIT] = hub_cfg_pkg::RESERVED_ONE_VALUE;   // RL5
        read_byte[hub_cfg_pkg::GANGED_BIT] = ganged;
        read_byte[hub_cfg_pkg::PM_OFF_N_BIT] = pm_off_n;
    endfunction

    assign hit = addr_hit(cfg_addr_i);
    assign mode_on = mode_active(i2c_mode_i, smbus_mode_i);
    assign cfg_write_ok = cfg_wr_i & hit & mode_on;   // RL4

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // low only until the first enabled edge after reset release
    always_comb begin
        strap_done_d = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_done_q <= 1'b0;
        end else if (ce_i) begin
            strap_done_q <= strap_done_d;
        end
    end

    // ------------------------------------------------------------
    // configuration bits
    // ------------------------------------------------------------
    logic serial_we_q, serial_we_d;
    logic lpm_dis_q, lpm_dis_d;
    logic ganged_q, ganged_d;
    logic pm_off_n_q, pm_off_n_d;

    always_comb begin
        serial_we_d = serial_we_q;
        lpm_dis_d = lpm_dis_q;
        ganged_d = ganged_q;
        pm_off_n_d = pm_off_n_q;
        if (!strap_done_q) begin
            // first enabled edge after release samples the straps; writes there are dropped
            ganged_d = ganging_strap_pin_i;   // RL6
            pm_off_n_d = power_mgmt_strap_pin_i;   // RL8
        end else if (cfg_write_ok) begin
            serial_we_d = cfg_wdata_i[hub_cfg_pkg::SERIAL_WE_BIT];   // RL1
            lpm_dis_d = cfg_wdata_i[hub_cfg_pkg::LPM_DISABLE_BIT];   // RL4
            ganged_d = cfg_wdata_i[hub_cfg_pkg::GANGED_BIT];   // RL4
            pm_off_n_d = cfg_wdata_i[hub_cfg_pkg::PM_OFF_N_BIT];   // RL4
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_we_q <= hub_cfg_pkg::SERIAL_WE_RESET;   // RL1
            lpm_dis_q <= hub_cfg_pkg::LPM_DISABLE_RESET;
            ganged_q <= 1'b0;
            pm_off_n_q <= 1'b0;
        end else if (ce_i) begin
            serial_we_q <= serial_we_d;
            lpm_dis_q <= lpm_dis_d;
            ganged_q <= ganged_d;
            pm_off_n_q <= pm_off_n_d;
        end
    end

    // ------------------------------------------------------------
    // forced link power state
    // ------------------------------------------------------------
    // once a forced accept is seen, U1/U2 stay usable until reset or upstream loss
    logic forced_q, forced_d;

    always_comb begin
        forced_d = forced_q;
        // set wins over the disconnect clear
        if (force_lpm_accept_i) begin
            forced_d = 1'b1;   // RL3
        end else if (upstream_disconnect_i) begin
            forced_d = 1'b0;   // RL3
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            forced_q <= 1'b0;   // RL3
        end else if (ce_i) begin
            forced_q <= forced_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read data is registered, so it follows the address by one cycle
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    always_comb begin
        rdata_d = 8'h00;
        if (hit) begin
            rdata_d = read_byte(serial_we_q, lpm_dis_q, ganged_q, pm_off_n_q);   // RL10
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    logic u1u2_d, ser_ok_d, oc_d;
    logic [PORTS-1:0] pwr_d;
    logic u1u2_q, ser_ok_q, oc_q;
    logic [PORTS-1:0] pwr_q;

    port_power_route #(
        .PORTS(PORTS)
    ) u_route (
        .ganged_i(ganged_q),
        .pm_off_n_i(pm_off_n_q),
        .port_req_i(port_req_i),
        .port_power_o(pwr_d)
    );

    always_comb begin
        // the forced state overrides the disable bit
        u1u2_d = !lpm_dis_q | forced_q;   // RL2
        ser_ok_d = serial_wr_i & serial_we_q & mode_on;   // RL1
        oc_d = overcurrent_i & !pm_off_n_q;   // RL9
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            u1u2_q <= 1'b0;
            ser_ok_q <= 1'b0;
            oc_q <= 1'b0;
            pwr_q <= '0;
        end else if (ce_i) begin
            u1u2_q <= u1u2_d;
            ser_ok_q <= ser_ok_d;
            oc_q <= oc_d;
            pwr_q <= pwr_d;   // RL7
        end
    end

    assign cfg_rdata_o = rdata_q;
    assign serial_string_write_enable_o = serial_we_q;
    assign u1u2_allowed_o = u1u2_q;
    assign serial_wr_ok_o = ser_ok_q;
    assign overcurrent_report_o = oc_q;
    assign port_power_control_pins_o = pwr_q;
endmodule
`default_nettype wire

// ### sim/cfg_host_model.sv
// behavioural configuration host that issues single register writes
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
    input wire logic mclk_i,                // clock
    input wire logic go_i,                  // issue one write
    input wire logic [7:0] data_i,          // byte to write
    output logic cfg_wr_o = 1'b0,           // write strobe
    output logic [7:0] cfg_wdata_o = 8'h00  // write data
);
    // launch just after an edge, hold one cycle; idle data toggles so stale bytes never match
    always @(posedge mclk_i) begin
        cfg_wr_o <= go_i;
        cfg_wdata_o <= go_i ? data_i : ~cfg_wdata_o;
    end
endmodule
`default_nettype wire

// ### sim/hub_device_config_bits_checker.sv
// concurrent checks on the device configuration bits ports
`timescale 1ns/10ps
`default_nettype none
module hub_device_config_bits_checker #(parameter int PORTS = 2) (
    input wire logic mclk_i, input wire logic rstn_i,  // clock, reset
    input wire logic ganging_strap_pin_i, input wire logic power_mgmt_strap_pin_i,  // straps
    input wire logic i2c_mode_i, input wire logic smbus_mode_i, input wire logic cfg_wr_i,
    input wire logic [3:0] cfg_addr_i, input wire logic [7:0] cfg_wdata_i,
    input wire logic force_lpm_accept_i, input wire logic upstream_disconnect_i,
    input wire logic overcurrent_i, input wire logic [PORTS-1:0] port_req_i,
    input wire logic serial_wr_i, input wire logic [7:0] cfg_rdata_o,
    input wire logic serial_string_write_enable_o, input wire logic u1u2_allowed_o,
    input wire logic serial_wr_ok_o, input wire logic overcurrent_report_o,
    input wire logic [PORTS-1:0] port_power_control_pins_o  // watched outputs
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic w1_q, w2_q, a5_q, st;
    // st: register settled for two cycles and read address was 5
    always_ff @(posedge mclk_i or negedge rstn_i)
        if (!rstn_i) {w1_q, w2_q, a5_q} <= 3'h6;
        else {w1_q, w2_q, a5_q} <= {cfg_wr_i | force_lpm_accept_i | upstream_disconnect_i,
            w1_q, cfg_addr_i == 4'h5};
    assign st = !w1_q && !w2_q && a5_q;
    a_reserved_one: assert property (st |-> cfg_rdata_o[4] && cfg_rdata_o[7] == 1'b0
        && cfg_rdata_o[1:0] == 2'h0) else $error("reserved bits wrong");
    a_other_addr: assert property (!a5_q && $past(rstn_i) |-> cfg_rdata_o == 8'h00)
        else $error("read of other offset not zero");
    a_strap_capture: assert property (!$past(rstn_i, 3) && $past(rstn_i, 2) && a5_q |->
        cfg_rdata_o[3:2] == {$past(ganging_strap_pin_i, 2), $past(power_mgmt_strap_pin_i, 2)})
        else $error("straps not captured");
    a_write_takes: assert property (cfg_wr_i && cfg_addr_i == 4'h5 && $past(rstn_i)
        && (i2c_mode_i || smbus_mode_i) |-> ##2 ($past(cfg_wr_i) || !a5_q ||
        cfg_rdata_o == (($past(cfg_wdata_i, 2) & 8'h6c) | 8'h10))) else $error("write lost");
    a_lpm_gate: assert property (st && !cfg_rdata_o[5] |-> u1u2_allowed_o)
        else $error("low power blocked while enabled");
    a_force_reenable: assert property (force_lpm_accept_i |-> ##[1:2] u1u2_allowed_o)
        else $error("forced accept ignored");
    a_serial_gate: assert property (st |-> serial_string_write_enable_o == cfg_rdata_o[6]
        && serial_wr_ok_o == ($past(serial_wr_i) && serial_string_write_enable_o
        && ($past(i2c_mode_i) || $past(smbus_mode_i)))) else $error("serial gate wrong");
    a_power_route: assert property (st |-> port_power_control_pins_o == (cfg_rdata_o[2] ?
        {PORTS{1'b1}} : cfg_rdata_o[3] ? PORTS'(|$past(port_req_i)) : $past(port_req_i))
        && overcurrent_report_o == ($past(overcurrent_i) && !cfg_rdata_o[2]))
        else $error("power routing wrong");
endmodule
bind hub_device_config_bits hub_device_config_bits_checker #(.PORTS(PORTS)) i_checker(
    .mclk_i(mclk_i), .rstn_i(rstn_i), .i2c_mode_i(i2c_mode_i), .smbus_mode_i(smbus_mode_i),
    .ganging_strap_pin_i(ganging_strap_pin_i), .power_mgmt_strap_pin_i(power_mgmt_strap_pin_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .force_lpm_accept_i(force_lpm_accept_i), .upstream_disconnect_i(upstream_disconnect_i),
    .overcurrent_i(overcurrent_i), .port_req_i(port_req_i), .serial_wr_i(serial_wr_i),
    .cfg_rdata_o(cfg_rdata_o), .serial_string_write_enable_o(serial_string_write_enable_o),
    .u1u2_allowed_o(u1u2_allowed_o), .serial_wr_ok_o(serial_wr_ok_o),
    .overcurrent_report_o(overcurrent_report_o),
    .port_power_control_pins_o(port_power_control_pins_o));
`default_nettype wire

// ### sim/hub_device_config_bits_test.sv
// self-checking testbench for the device configuration bits
`timescale 1ns/10ps
`default_nettype none
module hub_device_config_bits_test;
    logic mclk_i = 0, rstn_i = 0, go = 0, i2c = 0, smb = 0, fo = 0, dis = 0, oc = 0, sw = 0;
    logic gs = 0, ps = 0, look = 0, frc = 0, wr, u1, we, sok, ocr;
    logic [1:0] req = 0, pins;
    logic [3:0] addr = 4'h5;
    logic [7:0] d = 0, m = 0, wd, rd;
    logic [15:0] q[$];
    int failures = 0, checks = 0, cyc = 0;
    cfg_host_model i_cfg_host_model(.mclk_i(mclk_i), .go_i(go), .data_i(d), .cfg_wr_o(wr),
        .cfg_wdata_o(wd));
    hub_device_config_bits i_hub_device_config_bits(.mclk_i(mclk_i), .rstn_i(rstn_i),
        .ce_i(1'b1), .ganging_strap_pin_i(gs), .power_mgmt_strap_pin_i(ps), .i2c_mode_i(i2c),
        .smbus_mode_i(smb), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wd),
        .force_lpm_accept_i(fo), .upstream_disconnect_i(dis), .u1u2_req_i(sw),
        .overcurrent_i(oc), .port_req_i(req), .serial_wr_i(sw), .cfg_rdata_o(rd),
        .serial_string_write_enable_o(we), .u1u2_allowed_o(u1), .serial_wr_ok_o(sok),
        .overcurrent_report_o(ocr), .port_power_control_pins_o(pins));
    initial forever #5 mclk_i = ~mclk_i;
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            summarize();
        end
    end
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    always @(negedge mclk_i) if (look) cmp(q.pop_front(), {rd, 2'h0, we, u1, sok, ocr, pins});
    task automatic step(input logic w, input logic f, input logic x, input logic [7:0] v);
        @(posedge mclk_i);
        {i2c, smb, oc, sw, req} <= 6'($urandom);
        go <= w; d <= v; fo <= f; dis <= x;
        @(posedge mclk_i);
        go <= 0; fo <= 0; dis <= 0;
        repeat (4) @(posedge mclk_i);
        if (w && (i2c || smb) && addr == 4'h5) m = {1'b0, v[6:5], 1'b1, v[3:2], 2'h0};
        if (f) frc = 1;
        else if (x) frc = 0;
        q.push_back({addr == 4'h5 ? m : 8'h00, 2'h0, m[6], !m[5] | frc,
            sw & m[6] & (i2c | smb), oc & !m[2], m[2] ? 2'h3 : m[3] ? {1'b0, |req} : req});
        look <= 1;
        @(posedge mclk_i);
        look <= 0;
    endtask
    task automatic do_reset();
        rstn_i <= 0; gs <= 1'($urandom); ps <= 1'($urandom); frc = 0;
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1;
        m = {4'h1, gs, ps, 2'h0};
        step(0, 0, 0, 8'h00);
        $display("test reset and straps done");
    endtask
    initial begin
        void'($urandom(56));
        do_reset();
        for (int i = 0; i < 16; i++) step(1, 0, 0, 8'($urandom));
        $display("test writes and modes done");
        while (!m[5]) step(1, 0, 0, 8'hff);
        step(0, 1, 0, 8'h00);
        step(0, 0, 1, 8'h00);
        $display("test forced low power done");
        addr <= 4'h3;
        step(1, 0, 0, 8'h00);
        addr <= 4'h5;
        step(0, 0, 0, 8'h00);
        $display("test other offset done");
        do_reset();
        summarize();
    end
endmodule
`default_nettype wire
